// *** pkg/tsfc_defs.svh ***
// register offsets, field positions, reset values for the timer status block
`ifndef TSFC_DEFS_SVH
`define TSFC_DEFS_SVH
`define TSFC_CH_NUM       5
`define TSFC_CNT_W        16
`define TSFC_ADDR_W       8
`define TSFC_STAT_BASE    8'h00
`define TSFC_CNT_BASE     8'h10
`define TSFC_IEN_BASE     8'h20
`define TSFC_MODE_BASE    8'h30
`define TSFC_STAT_RST     8'hC0
`define TSFC_IEN_RST      8'h40
`define TSFC_CNT_RST      16'h0000
`define TSFC_CNT_MAX      16'hFFFF
`define TSFC_CNT_ONE      16'h0001
`define TSFC_BIT_DIR      7
`define TSFC_BIT_RSV6     6
`define TSFC_BIT_UDF      5
`define TSFC_BIT_OVF      4
`define TSFC_BIT_CCD      3
`define TSFC_BIT_CCC      2
`define TSFC_BIT_CCB      1
`define TSFC_BIT_CCA      0
`define TSFC_MODE_UPDN    0
`define TSFC_MODE_CPWM    1
`endif

// *** pkg/tsfc_pkg.sv ***
// types shared by the timer status and counter block
`default_nettype none
package tsfc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tsfc_bus_req_t;

  typedef struct packed {
    logic [3:0] cap;
    logic [3:0] cmp_en;
    logic [3:0] cmp_is_oc;
    logic [3:0] xfer_done;
  } tsfc_ev_t;

  typedef enum logic [1:0] {
    TSFC_IDLE,
    TSFC_READ_SEEN
  } tsfc_clr_st_t;
endpackage
`default_nettype wire

// *** hdl/tsfc_chan.sv ***
// one timer channel: counter, status flags, clear handshake
`default_nettype none
`include "tsfc_defs.svh"
module tsfc_chan #(
  parameter int CH    = 0,
  parameter int CNT_W = `TSFC_CNT_W
) (
  // clock and resets
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_standby,
  // count control
  input  wire logic             i_run,
  input  wire logic             i_updn_mode,
  input  wire logic             i_cpwm_mode,
  input  wire logic             i_dir_down,
  input  wire logic [CNT_W-1:0] i_gen_a,
  input  wire logic [CNT_W-1:0] i_gen_b,
  input  wire logic [CNT_W-1:0] i_gen_c,
  input  wire logic [CNT_W-1:0] i_gen_d,
  input  wire tsfc_pkg::tsfc_ev_t i_ev,
  input  wire logic             i_ovf_xfer_done,
  // software access
  input  wire logic             i_stat_rd,
  input  wire logic             i_stat_wr,
  input  wire logic             i_cnt_wr,
  input  wire logic [15:0]      i_wdata,
  // state
  output logic [7:0]            o_stat,
  output logic [CNT_W-1:0]      o_cnt
);
  localparam logic HAS_UDF = (CH == 1) || (CH == 2);
  localparam logic HAS_CD  = (CH == 0) || (CH == 3) || (CH == 4);
  localparam logic HAS_DIR = (CH != 0);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             dir_up;
    logic             udf;
    logic             ovf;
    logic [3:0]       cc;
    logic [7:0]       seen;
  } chan_st_t;

  chan_st_t st_q;
  chan_st_t st_d;
  logic     can_down;
  logic     going_down;
  logic [3:0] hit;
  logic [CNT_W-1:0] gen [4];

  assign gen[0] = i_gen_a;
  assign gen[1] = i_gen_b;
  assign gen[2] = i_gen_c;
  assign gen[3] = i_gen_d;

  // channel 0 up only; 1/2 need phase/cascade mode; 3/4 need cpwm
  assign can_down   = (CH == 1 || CH == 2) ? i_updn_mode :
                      (CH >= 3) ? i_cpwm_mode : 1'b0;
  assign going_down = can_down & i_dir_down;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hit
      // compare match or capture event per general register
      assign hit[g] = (i_ev.cmp_en[g] & i_ev.cmp_is_oc[g] & (st_q.cnt == gen[g]))
                    | (i_ev.cap[g] & ~i_ev.cmp_is_oc[g]);
    end
  endgenerate

  always_comb begin
    logic set_ovf;
    logic set_udf;
    logic [3:0] sw_clr;
    logic ovf_clr;
    logic udf_clr;
    set_ovf = 1'b0;
    set_udf = 1'b0;
    sw_clr  = 4'h0;
    ovf_clr = 1'b0;
    udf_clr = 1'b0;
    st_d    = st_q;
    if (i_run) begin
      if (going_down) begin
        st_d.cnt    = CNT_W'(st_q.cnt - `TSFC_CNT_ONE);
        st_d.dir_up = 1'b0;
        set_udf     = (st_q.cnt == `TSFC_CNT_RST);
        set_ovf     = (CH == 4) && i_cpwm_mode && (st_q.cnt == `TSFC_CNT_ONE);
      end else begin
        st_d.cnt    = CNT_W'(st_q.cnt + `TSFC_CNT_ONE);
        st_d.dir_up = 1'b1;
        set_ovf     = (st_q.cnt == `TSFC_CNT_MAX);
      end
    end
    if (i_cnt_wr) begin
      st_d.cnt = i_wdata[CNT_W-1:0];
    end
    // software clear needs a prior read that saw the bit at 1
    if (i_stat_rd) begin
      st_d.seen = st_d.seen | o_stat;
    end
    sw_clr  = {4{i_stat_wr}} & ~i_wdata[3:0] & st_q.seen[3:0];
    ovf_clr = (i_stat_wr & ~i_wdata[`TSFC_BIT_OVF] & st_q.seen[`TSFC_BIT_OVF])
            | ((CH == 4) & i_ovf_xfer_done);
    udf_clr = i_stat_wr & ~i_wdata[`TSFC_BIT_UDF] & st_q.seen[`TSFC_BIT_UDF];
    if (i_stat_wr) begin
      st_d.seen = 8'h00;
    end
    // transfer completion clears a/b/c/d; set still wins
    st_d.cc  = (st_q.cc & ~(sw_clr | i_ev.xfer_done)) | hit;
    st_d.ovf = (st_q.ovf & ~ovf_clr) | set_ovf;
    st_d.udf = HAS_UDF & ((st_q.udf & ~udf_clr) | set_udf);
    if (!HAS_CD) begin
      st_d.cc[3:2] = 2'b00;
    end
  end

  // manual reset does not reach here; only power-on and standby
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_standby) begin
      st_q        <= '0;
      st_q.dir_up <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_cnt = st_q.cnt;
  assign o_stat = {HAS_DIR ? st_q.dir_up : 1'b1, 1'b1,
                   HAS_UDF ? st_q.udf : 1'b0,
                   st_q.ovf, st_q.cc};
endmodule
`default_nettype wire

// *** hdl/tsfc_top.sv ***
// five-channel timer status flags and counters with register port
//
// Function
// - bit 7 shows direction, ch0 reads 1
// - ch1/2 bit 5 sets on underflow
// - bit 5 reserved, reads 0 on 0/3/4
// - bit 4 sets on overflow, all channels
// - ch4 cpwm: overflow also on 1 to 0
// - ch4 overflow cleared by transfer done
// - software writes only clear flags
// - compare match sets capture/compare flag
// - input capture sets capture/compare flag
// - c/d flags only on channels 0/3/4
// - a/b/c/d cleared by transfer completion
// - a cleared by dma completion
// - five 16-bit counters, reset to zero
// - ch0 up; ch1/2 down only special modes
// - ch3/4 up/down only in cpwm
// - status reset by power-on and standby
// - overflow irq when flag and enable set
`default_nettype none
`include "tsfc_defs.svh"
module tsfc_top #(
  parameter int CH_NUM = `TSFC_CH_NUM,
  parameter int CNT_W  = `TSFC_CNT_W
) (
  // clock, reset, standby
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_standby,
  // register port
  input  wire tsfc_pkg::tsfc_bus_req_t i_bus,
  output logic [15:0]               o_rdata,
  // per-channel timing inputs
  input  wire logic [CH_NUM-1:0]    i_run,
  input  wire logic [CH_NUM-1:0]    i_dir_down,
  input  wire logic [CH_NUM*4*CNT_W-1:0] i_gen,
  input  wire tsfc_pkg::tsfc_ev_t [CH_NUM-1:0] i_ev,
  input  wire logic [CH_NUM-1:0]    i_ovf_xfer_done,
  // overflow interrupt requests
  output logic [CH_NUM-1:0]         o_ovf_irq
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0]             rdata;
    logic [CH_NUM-1:0]       ovf_irq;
    logic [CH_NUM-1:0][7:0]  ien;
    logic [CH_NUM-1:0][1:0]  mode;
  } top_st_t;

  top_st_t st_q;
  top_st_t st_d;
  logic [CH_NUM-1:0][7:0]       stat;
  logic [CH_NUM-1:0][CNT_W-1:0] cnt;
  logic [CH_NUM-1:0]            stat_rd;
  logic [CH_NUM-1:0]            stat_wr;
  logic [CH_NUM-1:0]            cnt_wr;

  ////////////////////////////////////////////////////////////////////////
  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : g_ch
      // word-wide decode only; the port has no byte lanes
      assign stat_rd[c] = i_bus.rd && (i_bus.addr == (`TSFC_STAT_BASE + 8'(c)));
      assign stat_wr[c] = i_bus.wr && (i_bus.addr == (`TSFC_STAT_BASE + 8'(c)));
      assign cnt_wr[c]  = i_bus.wr && (i_bus.addr == (`TSFC_CNT_BASE + 8'(c)));
      tsfc_chan #(
        .CH    (c),
        .CNT_W (CNT_W)
      ) u_chan (
        .i_core_clk      (i_core_clk),
        .i_rst_n         (i_rst_n),
        .i_standby       (i_standby),
        .i_run           (i_run[c]),
        .i_updn_mode     (st_q.mode[c][`TSFC_MODE_UPDN]),
        .i_cpwm_mode     (st_q.mode[c][`TSFC_MODE_CPWM]),
        .i_dir_down      (i_dir_down[c]),
        .i_gen_a         (i_gen[(c*4+0)*CNT_W +: CNT_W]),
        .i_gen_b         (i_gen[(c*4+1)*CNT_W +: CNT_W]),
        .i_gen_c         (i_gen[(c*4+2)*CNT_W +: CNT_W]),
        .i_gen_d         (i_gen[(c*4+3)*CNT_W +: CNT_W]),
        .i_ev            (i_ev[c]),
        .i_ovf_xfer_done (i_ovf_xfer_done[c]),
        .i_stat_rd       (stat_rd[c]),
        .i_stat_wr       (stat_wr[c]),
        .i_cnt_wr        (cnt_wr[c]),
        .i_wdata         (i_bus.wdata),
        .o_stat          (stat[c]),
        .o_cnt           (cnt[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d       = st_q;
    st_d.rdata = 16'h0000;
    for (int i = 0; i < CH_NUM; i++) begin
      if (i_bus.rd && i_bus.addr == (`TSFC_STAT_BASE + 8'(i))) begin
        st_d.rdata = {8'h00, stat[i]};
      end
      if (i_bus.rd && i_bus.addr == (`TSFC_CNT_BASE + 8'(i))) begin
        st_d.rdata = 16'(cnt[i]);
      end
      if (i_bus.rd && i_bus.addr == (`TSFC_IEN_BASE + 8'(i))) begin
        st_d.rdata = {8'h00, st_q.ien[i]};
      end
      if (i_bus.rd && i_bus.addr == (`TSFC_MODE_BASE + 8'(i))) begin
        st_d.rdata = {14'h0000, st_q.mode[i]};
      end
      if (i_bus.wr && i_bus.addr == (`TSFC_IEN_BASE + 8'(i))) begin
        st_d.ien[i] = i_bus.wdata[7:0] | `TSFC_IEN_RST;
      end
      if (i_bus.wr && i_bus.addr == (`TSFC_MODE_BASE + 8'(i))) begin
        st_d.mode[i] = i_bus.wdata[1:0];
      end
      // registered from the flag as it now stands, one cycle late
      st_d.ovf_irq[i] = stat[i][`TSFC_BIT_OVF] & st_q.ien[i][`TSFC_BIT_OVF];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_standby) begin
      st_q.rdata   <= 16'h0000;
      st_q.ovf_irq <= '0;
      st_q.ien     <= {CH_NUM{`TSFC_IEN_RST}};
      st_q.mode    <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata   = st_q.rdata;
  assign o_ovf_irq = st_q.ovf_irq;
endmodule
`default_nettype wire

// *** bench/tsfc_top_monitor.sv ***
// concurrent checks on the ports of the timer status and counter block
`default_nettype none
module tsfc_top_monitor #(
  parameter int CH_NUM = 5,
  parameter int CNT_W  = 16
) (
  input wire logic                             i_core_clk,
  input wire logic                             i_rst_n,
  input wire logic                             i_standby,
  input wire tsfc_pkg::tsfc_bus_req_t          i_bus,
  input wire logic [15:0]                      o_rdata,
  input wire logic [CH_NUM-1:0]                i_run,
  input wire logic [CH_NUM-1:0]                i_dir_down,
  input wire logic [CH_NUM*4*CNT_W-1:0]        i_gen,
  input wire tsfc_pkg::tsfc_ev_t [CH_NUM-1:0] i_ev,
  input wire logic [CH_NUM-1:0]                i_ovf_xfer_done,
  input wire logic [CH_NUM-1:0]                o_ovf_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  idle_rdata_a: assert property (!i_bus.rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  dir_ch0_a: assert property (!i_standby && i_bus.rd && i_bus.addr == 8'h00 |=> o_rdata[7])
    else $error("channel 0 direction bit read as 0");
  udf_reserved_a:
    assert property (i_bus.rd && i_bus.addr inside {8'h00, 8'h03, 8'h04} |=> !o_rdata[5])
    else $error("reserved underflow bit read as 1");
  cd_reserved_a:
    assert property (i_bus.rd && i_bus.addr inside {8'h01, 8'h02} |=> o_rdata[3:2] == 2'h0)
    else $error("reserved c/d flags read as 1");
  standby_irq_a: assert property (i_standby [*2] |=> o_ovf_irq == '0)
    else $error("overflow request survives standby");
  standby_cnt_a:
    assert property (i_standby ##1 (i_bus.rd && i_bus.addr == 8'h10) |=> o_rdata == 16'h0000)
    else $error("counter not zero after standby");
  standby_stat_a:
    assert property (i_standby ##1 (!i_standby && i_bus.rd && i_bus.addr == 8'h00)
      |=> o_rdata == 16'h00C0)
    else $error("status not initial after standby");
  ch0_inc_a:
    assert property ((!i_standby && i_bus.rd && i_bus.addr == 8'h10 && i_run[0]) ##1
      (!i_standby && i_bus.rd && i_bus.addr == 8'h10) |=> o_rdata == $past(o_rdata) + 16'h0001)
    else $error("channel 0 counter did not step up by one");
  cover property (i_bus.rd && i_bus.addr == 8'h00);
  cover property (i_standby ##1 i_bus.rd);
  cover property (o_ovf_irq[0]);
endmodule
bind tsfc_top tsfc_top_monitor #(.CH_NUM(CH_NUM), .CNT_W(CNT_W)) tsfc_top_monitor_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_standby(i_standby), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_run(i_run), .i_dir_down(i_dir_down), .i_gen(i_gen), .i_ev(i_ev),
  .i_ovf_xfer_done(i_ovf_xfer_done), .o_ovf_irq(o_ovf_irq));
`default_nettype wire

// *** bench/tsfc_top_tb.sv ***
// register-level testbench for the timer status and counter block
`default_nettype none
module tsfc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                          i_core_clk = 1'b0;
  logic                          i_rst_n = 1'b0;
  logic                          i_standby = 1'b0;
  tsfc_pkg::tsfc_bus_req_t       i_bus = '0;
  logic [15:0]                   o_rdata;
  logic [4:0]                    i_run = '0;
  logic [4:0]                    i_dir_down = 5'h1F;
  logic [319:0]                  i_gen = '0;
  tsfc_pkg::tsfc_ev_t [4:0]      i_ev = '0;
  logic [4:0]                    i_ovf_xfer_done = '0;
  logic [4:0]                    o_ovf_irq;
  int                            num_errors = 0;
  int                            n_tests = 0;
  tsfc_top tsfc_top_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_standby(i_standby),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_run(i_run), .i_dir_down(i_dir_down), .i_gen(i_gen),
    .i_ev(i_ev), .i_ovf_xfer_done(i_ovf_xfer_done), .o_ovf_irq(o_ovf_irq));
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_core_clk);
    i_bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 chk(o_rdata & m, e);
  endtask
  task automatic step(input logic [4:0] r);
    @(posedge i_core_clk);
    i_run <= r;
    @(posedge i_core_clk);
    i_run <= '0;
  endtask
  // standby released in the same edge as the read strobe
  task automatic standby_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_core_clk);
    i_standby <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_standby <= 1'b0;
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 chk(o_rdata, e);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_core_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      rd_chk(8'h00 + 8'(c), 16'hFFFF, 16'h00C0);
      rd_chk(8'h10 + 8'(c), 16'hFFFF, 16'h0000);
    end
    bus_wr(8'h31, 16'h0001);
    // down requested everywhere; only channel 1 may honour it here
    for (int c = 0; c < 5; c++) begin
      bus_wr(8'h10 + 8'(c), (c == 1) ? 16'h0000 : 16'hFFFF);
      step(5'h01 << c);
      rd_chk(8'h10 + 8'(c), 16'hFFFF, (c == 1) ? 16'hFFFF : 16'h0000);
      rd_chk(8'h00 + 8'(c), 16'hFFFF, (c == 1) ? 16'h0060 : 16'h00D0);
    end
    bus_wr(8'h20, 16'h0050);
    repeat (3) @(posedge i_core_clk);
    #1 chk({15'h0000, o_ovf_irq[0]}, 16'h0001);
    // any status write ends the read arming, so the next zero write must not clear
    bus_wr(8'h00, 16'h00FF);
    bus_wr(8'h00, 16'h0000);
    rd_chk(8'h00, 16'h0010, 16'h0010);
    bus_wr(8'h00, 16'h00FF);
    rd_chk(8'h00, 16'h0010, 16'h0010);
    bus_wr(8'h00, 16'h0000);
    rd_chk(8'h00, 16'hFFFF, 16'h00C0);
    #1 chk({15'h0000, o_ovf_irq[0]}, 16'h0000);
    @(posedge i_core_clk);
    i_gen[192 +: 64] <= {4{16'h0005}};
    i_ev[3].cmp_en <= 4'hF;
    i_ev[3].cmp_is_oc <= 4'hF;
    bus_wr(8'h13, 16'h0005);
    repeat (2) @(posedge i_core_clk);
    i_ev[3].cmp_en <= 4'h0;
    rd_chk(8'h03, 16'h000F, 16'h000F);
    @(posedge i_core_clk);
    i_ev[1].cap <= 4'hF;
    @(posedge i_core_clk);
    i_ev[1].cap <= 4'h0;
    rd_chk(8'h01, 16'h000F, 16'h0003);
    @(posedge i_core_clk);
    i_ev[3].xfer_done <= 4'hF;
    i_ovf_xfer_done <= 5'h14;
    @(posedge i_core_clk);
    i_ev[3].xfer_done <= 4'h0;
    i_ovf_xfer_done <= 5'h00;
    rd_chk(8'h03, 16'hFFFF, 16'h00D0);
    rd_chk(8'h04, 16'h0010, 16'h0000);
    rd_chk(8'h02, 16'h0010, 16'h0010);
    // armed clear of a and b meets a capture on a in the same cycle
    @(posedge i_core_clk);
    i_ev[1].cap <= 4'h1;
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: 8'h01, wdata: 16'h0000};
    @(posedge i_core_clk);
    i_ev[1].cap <= 4'h0;
    i_bus <= '0;
    rd_chk(8'h01, 16'h0003, 16'h0001);
    bus_wr(8'h34, 16'h0002);
    bus_wr(8'h14, 16'h0001);
    step(5'h10);
    rd_chk(8'h14, 16'hFFFF, 16'h0000);
    rd_chk(8'h04, 16'h00F0, 16'h0050);
    @(posedge i_core_clk);
    i_run <= 5'h01;
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: 8'h10, wdata: 16'h0000};
    repeat (2) @(posedge i_core_clk);
    i_run <= 5'h00;
    i_bus <= '0;
    standby_rd(8'h00, 16'h00C0);
    standby_rd(8'h10, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
